// ---- rtl/pps_and_report_timing.sv ----
`timescale 1ns/10ps
// Summary of operation
// - second pulse stays high 100 ms, then low for rest of second
// - second pulse repeats every second once armed
// - default: arm on 3d fix, align second to navigation second strobe
// - start mode may arm on 2d fix or straight after power-up
// - augmentation correction enabled by default, software can disable
// - with correction enabled report rate capped at five per second
// - serial link defaults to 9600 baud, 8 data bits, 1 stop, no parity
// - software baud select switches link to higher rates
// - one solution tick per second
// - main sentences each second, satellite group every five seconds
// - settings return to defaults when both supplies were lost
// - rtc counts crystal edges while backup supply is present
// - fast reacquisition when orbit data stored and time known
// - logger defaults stop-when-full, basic content, every 15 seconds
// - without fix, position cleared unless retention enabled
// - fence flags position inside circle around preset point
// - standby on command, any received byte wakes
module pps_and_report_timing
  import pps_timing_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_MS * (CLK_HZ / 1000),
  parameter int unsigned PULSE_CYCLES = PULSE_MS * (CLK_HZ / 1000),
  parameter int unsigned BAUD_BASE_CYCLES = CLK_HZ / BAUD_DEFAULT
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // navigation engine
  input wire logic fix_2d_i,
  input wire logic fix_3d_i,
  input wire logic nav_second_i,
  input wire pos_s pos_i,
  input wire logic log_full_i,
  input wire logic nv_orbit_present_i,
  input wire logic rx_byte_i,
  // pins
  input wire logic backup_supply_pin_i,
  input wire logic rtc_xtal_i,
  // outputs
  output logic second_pulse_output_o,
  output logic fix_tick_o,
  output logic report_strobe_o,
  output logic gsv_strobe_o,
  output logic log_strobe_o,
  output logic baud_tick_o,
  output logic sbas_enable_o,
  output logic position_clear_o,
  output logic fence_inside_o,
  output logic fast_reacq_o,
  output logic standby_o
);
  localparam int unsigned SLOT_CYCLES = SEC_CYCLES / 10;

  function automatic logic [15:0] baud_limit(input logic [2:0] sel);
    case (sel)
      3'h1: baud_limit = 16'(BAUD_BASE_CYCLES / 2 - 1);
      3'h2: baud_limit = 16'(BAUD_BASE_CYCLES / 4 - 1);
      3'h3: baud_limit = 16'(BAUD_BASE_CYCLES / 6 - 1);
      3'h4: baud_limit = 16'(BAUD_BASE_CYCLES / 12 - 1);
      default: baud_limit = 16'(BAUD_BASE_CYCLES - 1);
    endcase
  endfunction

  // ==========================================
  // pin synchronisers, no reset so they track the pins through reset
  logic [2:0] bsync_q, xsync_q;
  logic backup_ok_q, xlvl_q;
  always_ff @(posedge clk_i) begin
    bsync_q <= {bsync_q[1:0], backup_supply_pin_i};
    xsync_q <= {xsync_q[1:0], rtc_xtal_i};
    if (bsync_q[1] == bsync_q[2]) begin
      backup_ok_q <= bsync_q[2];
    end
    if (xsync_q[1] == xsync_q[2]) begin
      xlvl_q <= xsync_q[2];
    end
  end
  logic xtal_rise;
  assign xtal_rise = (xsync_q[1] == xsync_q[2]) && xsync_q[2] && !xlvl_q;

  // ==========================================
  // configuration and bus
  ctrl_s ctrl_q, ctrl_d;
  logic [3:0] rate_q, rate_d;
  logic [2:0] baud_q, baud_d;
  logic [15:0] log_q, log_d, radius_q, radius_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  run_state_e state_q, state_d;
  logic armed_q, armed_d, aligned_q, aligned_d;
  logic [14:0] rtc_frac_q, rtc_frac_d;
  logic [31:0] rtc_sec_q, rtc_sec_d;
  logic wr_ok;
  assign wr_ok = write_i && !wait_q && byteenable_i[0];

  always_comb begin
    ctrl_d = ctrl_q;
    rate_d = rate_q;
    baud_d = baud_q;
    log_d = log_q;
    radius_d = radius_q;
    state_d = state_q;
    // one wait state, then the answer
    wait_d = !((read_i || write_i) && wait_q);
    rdata_d = rdata_q;
    if (read_i && wait_q) begin
      case (address_i)
        CTRL_OFS: rdata_d = {24'h00_0000, ctrl_q};
        RATE_OFS: rdata_d = {28'h000_0000, rate_q};
        BAUD_OFS: rdata_d = {29'h0000_0000, baud_q};
        LOG_OFS: rdata_d = {16'h0000, log_q};
        RADIUS_OFS: rdata_d = {16'h0000, radius_q};
        STATUS_OFS: rdata_d = {26'h000_0000, fast_reacq_o, fence_inside_o,
                               backup_ok_q, state_q, aligned_q, armed_q};
        RTC_OFS: rdata_d = rtc_sec_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (wr_ok) begin
      case (address_i)
        CTRL_OFS: ctrl_d = ctrl_s'({writedata_i[7:6], 1'b0, writedata_i[4:0]});
        RATE_OFS: rate_d = writedata_i[3:0];
        BAUD_OFS: baud_d = writedata_i[2:0];
        LOG_OFS: log_d = writedata_i[15:0];
        RADIUS_OFS: radius_d = writedata_i[15:0];
        default: ;
      endcase
    end
    // command enters standby, in standby a wake byte wins over a set
    case (state_q)
      RUN: if (wr_ok && address_i == CTRL_OFS && writedata_i[5]) state_d = STANDBY;
      STANDBY: if (rx_byte_i) state_d = RUN;
      default: state_d = RUN;
    endcase
    if (rst_i) begin
      state_d = RUN;
      wait_d = 1'b1;
      rdata_d = 32'h0000_0000;
      // defaults return only after both supplies were lost
      if (!backup_ok_q) begin
        ctrl_d = ctrl_s'(CTRL_RESET);
        rate_d = RATE_RESET;
        baud_d = BAUD_RESET;
        log_d = LOG_RESET;
        radius_d = RADIUS_RESET;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    ctrl_q <= ctrl_d;
    rate_q <= rate_d;
    baud_q <= baud_d;
    log_q <= log_d;
    radius_q <= radius_d;
    wait_q <= wait_d;
    rdata_q <= rdata_d;
    state_q <= state_d;
  end
  assign readdata_o = rdata_q;
  assign waitrequest_o = wait_q;

  // ==========================================
  // second base, pulse and schedulers
  logic [27:0] sec_cnt_q, sec_cnt_d, slot_cnt_q, slot_cnt_d;
  logic [27:0] hi_cnt_q, hi_cnt_d;
  logic [3:0] slot_q, slot_d, acc_q, acc_d, eff_rate, cap, base;
  logic [4:0] sum;
  logic [2:0] gsv_q, gsv_d;
  logic [15:0] logc_q, logc_d, baud_cnt_q, baud_cnt_d;
  logic sec_tick, slot_tick, start_ok, run;
  logic pps_q, pps_d, fix_q, fix_d, rep_q, rep_d, gsv_o_q, gsv_o_d;
  logic log_o_q, log_o_d, baud_o_q, baud_o_d;
  logic pclr_q, pclr_d, fence_q, fence_d, fast_q, fast_d;
  logic [32:0] dist2;
  logic [31:0] r2;

  always_comb begin
    run = (state_q == RUN);
    case (ctrl_q.start_mode)
      START_3D: start_ok = fix_3d_i;
      START_2D: start_ok = fix_2d_i || fix_3d_i;
      START_POWERUP: start_ok = 1'b1;
      default: start_ok = 1'b0;
    endcase
    armed_d = armed_q || start_ok;
    aligned_d = aligned_q;
    // navigation second restarts the local second except in power-up start mode, else free run
    sec_tick = 1'b0;
    sec_cnt_d = sec_cnt_q + 28'h000_0001;
    if ((nav_second_i && ctrl_q.start_mode != START_POWERUP) ||
        sec_cnt_q == 28'(SEC_CYCLES - 1)) begin
      sec_tick = 1'b1;
      sec_cnt_d = 28'h000_0000;
      if (nav_second_i) aligned_d = 1'b1;
    end
    // rising edge on the tick, fixed high time
    pps_d = pps_q;
    hi_cnt_d = hi_cnt_q;
    if (!armed_q) begin
      pps_d = 1'b0;
    end else if (sec_tick) begin
      pps_d = 1'b1;
      hi_cnt_d = 28'h000_0001;
    end else if (pps_q) begin
      if (hi_cnt_q == 28'(PULSE_CYCLES)) pps_d = 1'b0;
      else hi_cnt_d = hi_cnt_q + 28'h000_0001;
    end
    // effective rate clipped by correction mode
    cap = ctrl_q.sbas_en ? RATE_SBAS_MAX : RATE_MAX;
    eff_rate = (rate_q == 4'h0) ? 4'h1 : ((rate_q > cap) ? cap : rate_q);
    slot_tick = 1'b0;
    slot_d = slot_q;
    slot_cnt_d = slot_cnt_q + 28'h000_0001;
    if (sec_tick) begin
      slot_d = 4'h0;
      slot_cnt_d = 28'h000_0000;
    end else if (slot_cnt_q == 28'(SLOT_CYCLES - 1) && slot_q < SLOTS - 4'h1) begin
      slot_tick = 1'b1;
      slot_d = slot_q + 4'h1;
      slot_cnt_d = 28'h000_0000;
    end
    // spread reports over ten slots, first one on the second
    base = sec_tick ? (SLOTS - eff_rate) : acc_q;
    sum = {1'b0, base} + {1'b0, eff_rate};
    acc_d = acc_q;
    rep_d = 1'b0;
    if (sec_tick || slot_tick) begin
      rep_d = run && (sum >= {1'b0, SLOTS});
      acc_d = (sum >= {1'b0, SLOTS}) ? 4'(sum - {1'b0, SLOTS}) : sum[3:0];
    end
    fix_d = run && sec_tick;
    gsv_d = gsv_q;
    gsv_o_d = 1'b0;
    if (sec_tick) begin
      gsv_o_d = run && (gsv_q == 3'h0);
      gsv_d = (gsv_q == GSV_PERIOD_S - 3'h1) ? 3'h0 : gsv_q + 3'h1;
    end
    // logger interval, halted when full in stop mode
    logc_d = logc_q;
    log_o_d = 1'b0;
    if (sec_tick) begin
      if (logc_q + 16'h0001 >= log_q) begin
        logc_d = 16'h0000;
        log_o_d = run && !(log_full_i && ctrl_q.log_stop_full);
      end else begin
        logc_d = logc_q + 16'h0001;
      end
    end
    baud_o_d = 1'b0;
    baud_cnt_d = baud_cnt_q + 16'h0001;
    if (baud_cnt_q >= baud_limit(baud_q)) begin
      baud_cnt_d = 16'h0000;
      baud_o_d = 1'b1;
    end
    // rtc from crystal edges, lost with the backup supply
    rtc_frac_d = rtc_frac_q;
    rtc_sec_d = rtc_sec_q;
    if (!backup_ok_q) begin
      rtc_frac_d = 15'h0000;
      rtc_sec_d = 32'h0000_0000;
    end else if (xtal_rise) begin
      rtc_frac_d = rtc_frac_q + 15'h0001;
      if (rtc_frac_q == 15'(RTC_HZ - 1)) rtc_sec_d = rtc_sec_q + 32'h0000_0001;
    end
    // position clear without fix unless retained
    pclr_d = !(fix_2d_i || fix_3d_i) && !ctrl_q.retain_en;
    dist2 = 33'(pos_i.east * pos_i.east) + 33'(pos_i.north * pos_i.north);
    r2 = radius_q * radius_q;
    fence_d = ctrl_q.fence_en && (fix_2d_i || fix_3d_i) && (dist2 <= {1'b0, r2});
    fast_d = nv_orbit_present_i && backup_ok_q;
    if (rst_i) begin
      armed_d = 1'b0;
      aligned_d = 1'b0;
      sec_cnt_d = 28'h000_0000;
      slot_cnt_d = 28'h000_0000;
      hi_cnt_d = 28'h000_0000;
      slot_d = 4'h0;
      acc_d = 4'h0;
      gsv_d = 3'h0;
      logc_d = 16'h0000;
      baud_cnt_d = 16'h0000;
      {pps_d, fix_d, rep_d, gsv_o_d, log_o_d, baud_o_d} = 6'h00;
      {pclr_d, fence_d, fast_d} = 3'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    armed_q <= armed_d;
    aligned_q <= aligned_d;
    sec_cnt_q <= sec_cnt_d;
    slot_cnt_q <= slot_cnt_d;
    hi_cnt_q <= hi_cnt_d;
    slot_q <= slot_d;
    acc_q <= acc_d;
    gsv_q <= gsv_d;
    logc_q <= logc_d;
    baud_cnt_q <= baud_cnt_d;
    rtc_frac_q <= rtc_frac_d;
    rtc_sec_q <= rtc_sec_d;
    {pps_q, fix_q, rep_q, gsv_o_q, log_o_q, baud_o_q} <=
      {pps_d, fix_d, rep_d, gsv_o_d, log_o_d, baud_o_d};
    {pclr_q, fence_q, fast_q} <= {pclr_d, fence_d, fast_d};
  end

  assign second_pulse_output_o = pps_q;
  assign fix_tick_o = fix_q;
  assign report_strobe_o = rep_q;
  assign gsv_strobe_o = gsv_o_q;
  assign log_strobe_o = log_o_q;
  assign baud_tick_o = baud_o_q;
  assign sbas_enable_o = ctrl_q.sbas_en;
  assign position_clear_o = pclr_q;
  assign fence_inside_o = fence_q;
  assign fast_reacq_o = fast_q;
  assign standby_o = (state_q == STANDBY);

  // ==========================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] rep_sec;
  always_ff @(posedge clk_i) begin
    // restart the count when the cap comes on, a faster second may be half spent
    rep_sec <= (rst_i || sec_tick || !ctrl_q.sbas_en) ? 4'h0 : rep_sec + {3'h0, rep_q};
  end
  chk_pulse_unarmed: assert property (!armed_q |=> !pps_q)
    else $error("pulse high before start condition");
  chk_pulse_rise: assert property ($rose(pps_q) |-> $past(sec_tick) && armed_q)
    else $error("pulse rose away from second tick");
  chk_pulse_width: assert property ($fell(pps_q) && !$past(sec_tick)
    |-> $past(hi_cnt_q) == 28'(PULSE_CYCLES))
    else $error("pulse width wrong");
  chk_sec_period: assert property (sec_cnt_q == 28'(SEC_CYCLES - 1)
    |=> sec_cnt_q == 28'h000_0000)
    else $error("second counter failed to wrap");
  chk_rate_cap: assert property (ctrl_q.sbas_en |-> rep_sec <= RATE_SBAS_MAX)
    else $error("report rate above cap");
  chk_gsv_tick: assert property (gsv_o_q |-> fix_q && rep_q)
    else $error("satellite group off the second");
  chk_standby_wake: assert property (state_q == STANDBY && rx_byte_i |=> !standby_o)
    else $error("wake byte ignored");
  chk_bus_wait: assert property ((read_i || write_i) && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer timing wrong");
  chk_fast_reacq: assert property (nv_orbit_present_i && backup_ok_q
    |=> fast_reacq_o)
    else $error("fast reacquisition missing");
  cov_pulse: cover property ($rose(pps_q));
  cov_gsv: cover property (gsv_o_q);
  cov_standby: cover property (state_q == STANDBY ##1 state_q == RUN);
  cov_log: cover property (log_strobe_o);
endmodule

// ---- rtl/pps_timing_pkg.sv ----
package pps_timing_pkg;
  // ==========================================
  // timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned SEC_MS = 1000;
  localparam int unsigned PULSE_MS = 100;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam int unsigned RTC_HZ = 32768;
  localparam logic [3:0] SLOTS = 4'hA;
  localparam logic [3:0] RATE_MAX = 4'hA;
  localparam logic [3:0] RATE_SBAS_MAX = 4'h5;
  localparam logic [2:0] GSV_PERIOD_S = 3'h5;
  // ==========================================
  // frame format, fixed 8n1
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;
  // ==========================================
  // register byte offsets
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] RATE_OFS = 5'h04;
  localparam logic [4:0] BAUD_OFS = 5'h08;
  localparam logic [4:0] LOG_OFS = 5'h0C;
  localparam logic [4:0] RADIUS_OFS = 5'h10;
  localparam logic [4:0] STATUS_OFS = 5'h14;
  localparam logic [4:0] RTC_OFS = 5'h18;
  // ==========================================
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h44;
  localparam logic [3:0] RATE_RESET = 4'h1;
  localparam logic [2:0] BAUD_RESET = 3'h0;
  localparam logic [15:0] LOG_RESET = 16'h000F;
  localparam logic [15:0] RADIUS_RESET = 16'h0000;
  // ==========================================
  // types
  typedef enum logic [1:0] {
    START_3D = 2'b00,
    START_2D = 2'b01,
    START_POWERUP = 2'b10
  } start_mode_e;
  typedef enum logic {
    RUN = 1'b0,
    STANDBY = 1'b1
  } run_state_e;
  typedef struct packed {
    logic log_content_full;
    logic log_stop_full;
    logic standby_req;
    logic fence_en;
    logic retain_en;
    logic sbas_en;
    start_mode_e start_mode;
  } ctrl_s;
  typedef struct packed {
    logic signed [15:0] east;
    logic signed [15:0] north;
  } pos_s;
endpackage

// ---- tb/host_link_model.sv ----
`timescale 1ns/10ps
// ==========================================
// host end of the serial link
module host_link_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link
  input wire logic baud_tick_i,
  input wire logic wake_i,
  output logic rx_byte_o,
  output int gap_o
);
  int since_q;
  int bits_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      since_q <= 0;
      gap_o <= 0;
    end else if (baud_tick_i) begin
      gap_o <= since_q + 1;
      since_q <= 0;
    end else begin
      since_q <= since_q + 1;
    end
  end
  always @(posedge clk_i) begin
    rx_byte_o <= 1'b0;
    if (rst_i) begin
      bits_q <= 0;
    end else if (bits_q == 0 && wake_i) begin
      bits_q <= 1;
    end else if (bits_q > 0 && baud_tick_i) begin
      if (bits_q == 10) begin
        bits_q <= 0;
        rx_byte_o <= 1'b1;
      end else begin
        bits_q <= bits_q + 1;
      end
    end
  end
endmodule

// ---- tb/pps_and_report_timing_tb_top.sv ----
`timescale 1ns/10ps
module pps_and_report_timing_tb_top;
  import pps_timing_pkg::*;
  // ==========================================
  // setup, short counts keep the run small
  localparam int SEC = 1000;
  localparam int PUL = 100;
  localparam int BB = 48;
  typedef struct {
    logic [7:0] ctrl;
    logic [3:0] rate;
    logic full;
    int rep;
    int logs;
  } row_s;
  row_s rows[5] = '{'{8'h44, 4'hA, 1'b0, 25, 1}, '{8'h40, 4'hA, 1'b0, 50, 1},
    '{8'h44, 4'h3, 1'b0, 15, 1}, '{8'h40, 4'h0, 1'b1, 5, 0}, '{8'h04, 4'h1, 1'b1, 5, 1}};
  logic [4:0] ra[6] = '{CTRL_OFS, RATE_OFS, BAUD_OFS, LOG_OFS, RADIUS_OFS, 5'h1C};
  logic [31:0] rv[6] = '{32'h0000_0044, 32'h0000_0001, 32'h0000_0000, 32'h0000_000F,
    32'h0000_0000, 32'h0000_0000};
  int bg[5] = '{48, 24, 12, 8, 4};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] address_i = 5'h00;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0000_0000;
  logic [3:0] byteenable_i = 4'hF;
  logic fix_2d_i = 1'b0;
  logic fix_3d_i = 1'b0;
  logic nav_second_i = 1'b0;
  pos_s pos_i = '0;
  logic log_full_i = 1'b0;
  logic nv_orbit_present_i = 1'b1;
  logic backup_supply_pin_i = 1'b0;
  logic rtc_xtal_i = 1'b0;
  logic rx_byte_i;
  logic [31:0] readdata_o;
  logic waitrequest_o, second_pulse_output_o, fix_tick_o, report_strobe_o, gsv_strobe_o;
  logic log_strobe_o, baud_tick_o, sbas_enable_o, position_clear_o, fence_inside_o;
  logic fast_reacq_o, standby_o;
  logic nav_en = 1'b0, wake = 1'b0, prev = 1'b0;
  logic [31:0] q;
  int miscompares, num_checks, cy, hi, hi_len, per, rise, navc, ncyc, xc, gap;
  int n_rep, n_gsv, n_fix, n_log, n_pul;

  pps_and_report_timing #(.SEC_CYCLES(SEC), .PULSE_CYCLES(PUL), .BAUD_BASE_CYCLES(BB)) dut_u (
    .clk_i, .rst_i, .address_i, .read_i, .write_i, .writedata_i, .byteenable_i, .readdata_o,
    .waitrequest_o, .fix_2d_i, .fix_3d_i, .nav_second_i, .pos_i, .log_full_i,
    .nv_orbit_present_i, .rx_byte_i, .backup_supply_pin_i, .rtc_xtal_i,
    .second_pulse_output_o, .fix_tick_o, .report_strobe_o, .gsv_strobe_o, .log_strobe_o,
    .baud_tick_o, .sbas_enable_o, .position_clear_o, .fence_inside_o, .fast_reacq_o,
    .standby_o);
  host_link_model host_u (.clk_i, .rst_i, .baud_tick_i(baud_tick_o), .wake_i(wake),
    .rx_byte_o(rx_byte_i), .gap_o(gap));

  always #2.5 clk_i = ~clk_i;
  // nav second strobe and a slow crystal, both off the clock edge by nba
  always @(posedge clk_i) begin
    ncyc <= (ncyc == SEC - 1) ? 0 : ncyc + 1;
    nav_second_i <= nav_en && ncyc == 0;
    xc <= (xc == 3051) ? 0 : xc + 1;
    if (xc == 0) rtc_xtal_i <= ~rtc_xtal_i;
  end
  // observers sample on the falling edge where outputs are settled
  always @(negedge clk_i) begin
    cy++;
    n_rep += report_strobe_o;
    n_gsv += gsv_strobe_o;
    n_fix += fix_tick_o;
    n_log += log_strobe_o;
    n_pul += second_pulse_output_o;
    if (nav_second_i) navc = cy;
    if (second_pulse_output_o && !prev) begin
      per = cy - rise;
      rise = cy;
    end
    if (second_pulse_output_o) hi++;
    else if (prev) begin
      hi_len = hi;
      hi = 0;
    end
    prev = second_pulse_output_o;
  end
  // ==========================================
  // tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("%0t test %s done", $time, s);
  endtask
  task automatic waitv(ref logic s, input logic v, input int lim);
    for (int k = 0; k < lim && s !== v; k++) @(posedge clk_i);
    if (s !== v) begin
      miscompares++;
      $display("[FAIL] %0t wait ran out", $time);
      summarize();
    end
  endtask
  // avalon access: hold until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= d;
    write_i <= wr;
    read_i <= !wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
    if (waitrequest_o !== 1'b0) begin
      miscompares++;
      $display("[FAIL] %0t bus wait ran out", $time);
      summarize();
    end
  endtask
  // synchronisers are not reset, so the backup level is set first
  task automatic reset_dut(input logic bk);
    @(posedge clk_i);
    backup_supply_pin_i <= bk;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    backup_supply_pin_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  // ==========================================
  // sequence
  initial begin
    int s0, s1, s2, s3;
    reset_dut(1'b0);
    foreach (ra[j]) begin
      bus(1'b0, ra[j], 32'h0000_0000);
      chk(q, rv[j]);
    end
    chk(position_clear_o, 1'b1);
    chk(sbas_enable_o, 1'b1);
    done("reset");
    nav_en <= 1'b1;
    fix_2d_i <= 1'b1;
    s0 = n_pul;
    repeat (2 * SEC) @(posedge clk_i);
    chk(n_pul - s0, 0);
    fix_3d_i <= 1'b1;
    repeat (2 * SEC) @(posedge clk_i);
    waitv(nav_second_i, 1'b1, SEC + 10);
    repeat (PUL + 10) @(posedge clk_i);
    chk(rise - navc, 1);
    chk(hi_len, PUL);
    chk(per, SEC);
    chk(fast_reacq_o, 1'b1);
    bus(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(q[1:0], 2'b11);
    done("pulse");
    bus(1'b1, RADIUS_OFS, 32'h0000_0005);
    bus(1'b1, CTRL_OFS, 32'h0000_0054);
    pos_i <= '{east: 16'h0003, north: 16'h0004};
    repeat (8) @(posedge clk_i);
    chk(fence_inside_o, 1'b1);
    pos_i <= '{east: 16'h0003, north: 16'h0005};
    repeat (8) @(posedge clk_i);
    chk(fence_inside_o, 1'b0);
    done("fence");
    bus(1'b1, LOG_OFS, 32'h0000_0005);
    foreach (rows[j]) begin
      log_full_i <= rows[j].full;
      bus(1'b1, CTRL_OFS, {24'h00_0000, rows[j].ctrl});
      bus(1'b1, RATE_OFS, {28'h000_0000, rows[j].rate});
      repeat (SEC) @(posedge clk_i);
      s0 = n_rep;
      s1 = n_gsv;
      s2 = n_fix;
      s3 = n_log;
      repeat (5 * SEC) @(posedge clk_i);
      chk(n_rep - s0, rows[j].rep);
      chk(n_gsv - s1, 1);
      chk(n_fix - s2, 5);
      chk(n_log - s3, rows[j].logs);
      chk(sbas_enable_o, rows[j].ctrl[2]);
    end
    byteenable_i <= 4'hE;
    bus(1'b1, RATE_OFS, 32'h0000_0007);
    byteenable_i <= 4'hF;
    bus(1'b0, RATE_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0001);
    done("rates");
    foreach (bg[j]) begin
      bus(1'b1, BAUD_OFS, j);
      repeat (3 * BB) @(posedge clk_i);
      chk(gap, bg[j]);
    end
    done("baud");
    bus(1'b1, CTRL_OFS, 32'h0000_0064);
    repeat (2) @(posedge clk_i);
    chk(standby_o, 1'b1);
    s0 = n_rep;
    repeat (SEC) @(posedge clk_i);
    chk(n_rep - s0, 0);
    wake <= 1'b1;
    waitv(standby_o, 1'b0, 20 * BB);
    wake <= 1'b0;
    done("standby");
    bus(1'b1, CTRL_OFS, 32'h0000_0046);
    nav_en <= 1'b0;
    fix_2d_i <= 1'b0;
    fix_3d_i <= 1'b0;
    reset_dut(1'b1);
    repeat (3 * SEC) @(posedge clk_i);
    chk(per, SEC);
    chk(hi_len, PUL);
    bus(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0046);
    bus(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(q[3], 1'b1);
    reset_dut(1'b0);
    bus(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(q, 32'h0000_0044);
    done("power");
    summarize();
  end
endmodule
